// ---- hdl/scc_defines.svh ----
/*
 * Constants of the serial EEPROM command controller: fixed address
 * prefix, filter and start-up timing figures.
 * Assumes inclusion by bare name from the design and the testbench.
 */
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

`define SCC_DEV_PREFIX      4'h a
`define SCC_CORE_PERIOD_NS  25
`define SCC_LINK_PERIOD_NS  160
`define SCC_GLITCH_NS       130
`define SCC_INIT_TIME_US    1000
`define SCC_BYTE_BITS       4'h8

`endif

// ---- hdl/scc_pkg.sv ----
/*
 * Types of the serial EEPROM command controller: bus states and the
 * state records of both clock domains.
 * Assumes scc_defines.svh is on the include path.
 */
package scc_pkg;

  typedef enum logic [2:0] {
    SCC_IDLE,
    SCC_DEV,
    SCC_ADDR_HI,
    SCC_ADDR_LO,
    SCC_DATA,
    SCC_WAIT
  } scc_state_e;

  typedef struct packed {
    logic [31:0] init_cnt;
    logic        init_done;
    logic        tog_s1;
    logic        tog_s2;
    logic        tog_s3;
    logic        commit;
    logic [15:0] addr;
    logic [7:0]  data;
  } scc_core_s;

  typedef struct packed {
    logic       init_s1;
    logic       init_s2;
    logic       scl_s1;
    logic       scl_s2;
    logic       sda_s1;
    logic       sda_s2;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic       scl_f;
    logic       sda_f;
    logic [3:0] scl_cnt;
    logic [3:0] sda_cnt;
    scc_state_e state;
    logic       ack_phase;
    logic [7:0] shift;
    logic [3:0] bits;
    logic [15:0] addr;
    logic [7:0] data;
    logic       got_data;
    logic       sda_oe;
    logic       tog;
  } scc_link_s;

endpackage : scc_pkg

// ---- hdl/scc_eeprom_ctrl.sv ----
/*
 * Command acceptance and write commit control of a two-wire serial EEPROM
 * slave. Link logic runs on a free-running sampling clock; start-up
 * lockout and the commit hand-off run on the core clock.
 * Assumes SCL/SDA arrive asynchronously and the bench resolves the
 * open-drain SDA wire from sda_oe_o.
 */
`timescale 1ns/100ps
`include "scc_defines.svh"

module scc_eeprom_ctrl #(
  parameter int INIT_CYC = (`SCC_INIT_TIME_US * 1000) / `SCC_CORE_PERIOD_NS
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        link_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [2:0]  dev_sel_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             standby_o,
  output logic             write_commit_o,
  output logic [15:0]      commit_addr_o,
  output logic [7:0]       commit_data_o
);
  import scc_pkg::*;

  // Least stable time rounds up: a 130 ns pulse spans at most one sample
  localparam int FILT_CYC =
    (`SCC_GLITCH_NS + `SCC_LINK_PERIOD_NS - 1) / `SCC_LINK_PERIOD_NS;

  scc_core_s core;
  scc_core_s next_core;
  scc_link_s lk;
  scc_link_s next_lk;

  ////////////////////////////////////////////////////////////////////////
  // Glitch filter: new level taken only after FILT_CYC+1 equal samples

  function automatic logic [4:0] filt(input logic cur, input logic smp,
                                      input logic [3:0] cnt);
    logic [4:0] res;
    res = {cur, 4'h0};
    if (smp != cur) begin
      if (cnt == 4'(FILT_CYC)) begin
        res = {smp, 4'h0};
      end else begin
        res = {cur, 4'(cnt + 4'h1)};
      end
    end
    return res;
  endfunction : filt

  ////////////////////////////////////////////////////////////////////////
  // Core domain: initialization timer and commit hand-off

  always_comb begin
    next_core        = core;
    next_core.commit = 1'b0;
    if (core.init_cnt != 32'(INIT_CYC)) begin
      next_core.init_cnt = core.init_cnt + 32'h0000_0001;
    end else begin
      next_core.init_done = 1'b1;
    end
    next_core.tog_s1 = lk.tog;
    next_core.tog_s2 = core.tog_s1;
    next_core.tog_s3 = core.tog_s2;
    // Address and data sit still in the link domain long after the toggle
    // Gated by standby: after a core-only reset the link toggle may still
    // sit at its old level and would otherwise fake a commit
    if (core.init_done && core.tog_s2 != core.tog_s3) begin
      next_core.commit = 1'b1;
      next_core.addr   = lk.addr;
      next_core.data   = lk.data;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  assign standby_o      = core.init_done;
  assign write_commit_o = core.commit;
  assign commit_addr_o  = core.addr;
  assign commit_data_o  = core.data;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: synchronisers, filter, start/stop and byte decoding

  logic [4:0] scl_nx;
  logic [4:0] sda_nx;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  always_comb begin
    next_lk         = lk;
    next_lk.init_s1 = core.init_done;
    next_lk.init_s2 = lk.init_s1;
    next_lk.scl_s1  = scl_i;
    next_lk.scl_s2  = lk.scl_s1;
    next_lk.sda_s1  = sda_i;
    next_lk.sda_s2  = lk.sda_s1;
    next_lk.pin_s1  = dev_sel_i;
    next_lk.pin_s2  = lk.pin_s1;
    scl_nx          = filt(lk.scl_f, lk.scl_s2, lk.scl_cnt);
    sda_nx          = filt(lk.sda_f, lk.sda_s2, lk.sda_cnt);
    next_lk.scl_f   = scl_nx[4];
    next_lk.scl_cnt = scl_nx[3:0];
    next_lk.sda_f   = sda_nx[4];
    next_lk.sda_cnt = sda_nx[3:0];
    scl_rise  = scl_nx[4] && !lk.scl_f;
    scl_fall  = !scl_nx[4] && lk.scl_f;
    start_det = lk.scl_f && scl_nx[4] && lk.sda_f && !sda_nx[4];
    stop_det  = lk.scl_f && scl_nx[4] && !lk.sda_f && sda_nx[4];

    if (!lk.init_s2) begin
      // Hold idle and silent until initialization ends. This domain has no
      // reset of its own, so every field past the synchronisers is cleared here; the filters track
      // the pin level so that leaving the hold shows no false edge
      next_lk.scl_f     = lk.scl_s2;
      next_lk.sda_f     = lk.sda_s2;
      next_lk.scl_cnt   = 4'h0;
      next_lk.sda_cnt   = 4'h0;
      next_lk.shift     = 8'h00;
      next_lk.addr      = 16'h0000;
      next_lk.data      = 8'h00;
      next_lk.tog       = 1'b0;
      next_lk.state     = SCC_IDLE;
      next_lk.ack_phase = 1'b0;
      next_lk.bits      = 4'h0;
      next_lk.got_data  = 1'b0;
      next_lk.sda_oe    = 1'b0;
    end else if (start_det) begin
      next_lk.state     = SCC_DEV;
      next_lk.ack_phase = 1'b0;
      next_lk.bits      = 4'h0;
      next_lk.got_data  = 1'b0;
      next_lk.sda_oe    = 1'b0;
    end else if (stop_det) begin
      // Stop's own SCL rise is counted as a bit, hence bits up to one
      if (lk.state == SCC_DATA && !lk.ack_phase && lk.got_data &&
          lk.bits <= 4'h1) begin
        next_lk.tog = !lk.tog;
      end
      next_lk.state     = SCC_IDLE;
      next_lk.ack_phase = 1'b0;
      next_lk.bits      = 4'h0;
      next_lk.got_data  = 1'b0;
      next_lk.sda_oe    = 1'b0;
    end else if (lk.state != SCC_IDLE && lk.state != SCC_WAIT) begin
      if (scl_rise && !lk.ack_phase && lk.bits != `SCC_BYTE_BITS) begin
        next_lk.shift = {lk.shift[6:0], lk.sda_f};
        next_lk.bits  = lk.bits + 4'h1;
      end else if (scl_fall && lk.ack_phase) begin
        next_lk.ack_phase = 1'b0;
        next_lk.sda_oe    = 1'b0;
        next_lk.bits      = 4'h0;
      end else if (scl_fall && lk.bits == `SCC_BYTE_BITS) begin
        next_lk.ack_phase = 1'b1;
        next_lk.sda_oe    = 1'b1;
        case (lk.state)
          SCC_DEV: begin
            if (lk.shift[7:1] == {`SCC_DEV_PREFIX, lk.pin_s2} && !lk.shift[0]) begin
              next_lk.state = SCC_ADDR_HI;
            end else begin
              // Reads and foreign addresses are not served here
              next_lk.state  = SCC_WAIT;
              next_lk.sda_oe = lk.shift[7:1] == {`SCC_DEV_PREFIX, lk.pin_s2};
            end
          end
          SCC_ADDR_HI: begin
            next_lk.addr[15:8] = lk.shift;
            next_lk.state      = SCC_ADDR_LO;
          end
          SCC_ADDR_LO: begin
            next_lk.addr[7:0] = lk.shift;
            next_lk.state     = SCC_DATA;
          end
          default: begin
            next_lk.data     = lk.shift;
            next_lk.got_data = 1'b1;
          end
        endcase
      end
    end else if (lk.state == SCC_WAIT && scl_fall && lk.ack_phase) begin
      next_lk.ack_phase = 1'b0;
      next_lk.sda_oe    = 1'b0;
    end
  end

  // No reset port here: the synchronised init level clears this domain
  always_ff @(posedge link_clk_i) begin
    lk <= next_lk;
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = lk.sda_oe;

endmodule : scc_eeprom_ctrl

// ---- tb/scc_chk_assertions.sv ----
/* Port checker of the command controller.
   Assumes it is bound onto scc_eeprom_ctrl. */
`timescale 1ns/100ps
module scc_chk_assertions (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        link_clk_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_oe_o,
  input wire logic        standby_o,
  input wire logic        write_commit_o,
  input wire logic [15:0] commit_addr_o,
  input wire logic [7:0]  commit_data_o
);
  sequence s_pulse;
    write_commit_o ##1 !write_commit_o;
  endsequence
  a_commit_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(write_commit_o) |-> s_pulse) else $error("commit pulse too long");
  a_commit_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    write_commit_o |-> scl_i && sda_i) else $error("commit without stop");
  a_result_stands: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $changed({commit_addr_o, commit_data_o}) |-> $past(write_commit_o) or ##[0:2] write_commit_o)
    else $error("commit result moved");
  // Four link edges allow for the standby level crossing into the link side
  a_lock_no_ack: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    !standby_o [*4] |-> !sda_oe_o) else $error("ack during start-up");
  a_lock_no_commit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !standby_o |-> !write_commit_o) else $error("commit during start-up");
  a_standby_held: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    standby_o |=> standby_o) else $error("standby dropped");
  a_init_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(standby_o) |-> !sda_oe_o [*4]) else $error("not idle after start-up");
  a_ack_scl_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    standby_o && $changed(sda_oe_o) |-> !scl_i) else $error("ack moved while clock high");
  a_ack_holds: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $rose(sda_oe_o) |=> sda_oe_o [*8]) else $error("ack too short");
endmodule : scc_chk_assertions

bind scc_eeprom_ctrl scc_chk_assertions chk_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
  .standby_o(standby_o), .write_commit_o(write_commit_o),
  .commit_addr_o(commit_addr_o), .commit_data_o(commit_data_o));

// ---- tb/scc_master.sv ----
/* Bus master model driving SCL and SDA.
   Assumes the bench resolves the pulled-up SDA wire into sda_i. */
`timescale 1ns/100ps
module scc_master (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  localparam int Q = 800;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // SDA released before SCL rises, so never while the slave pulls low
  task automatic start();
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask : stop
  // Optional 100 ns low spike while SCL is high
  task automatic bit_io(input logic b, input logic g, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    if (g) begin
      sda_o = 1'b0;
      #100 sda_o = 1'b1;
    end
    #Q scl_o = 1'b0;
  endtask : bit_io
  task automatic tx_byte(input logic [7:0] b, input logic g, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], g && b[i], r);
    bit_io(1'b1, 1'b0, r);
    ack = !r;
  endtask : tx_byte
endmodule : scc_master

// ---- tb/testbench.sv ----
/* Self-checking bench of the command controller.
   Assumes the master model and the checker are compiled first. */
`timescale 1ns/100ps
`include "scc_defines.svh"
module testbench;
  localparam logic [2:0] SEL = 3'h5;
  localparam logic [7:0] DEV = {`SCC_DEV_PREFIX, SEL, 1'b0};
  logic core_clk_i, link_clk_i, rst_n_i, scl, m_sda, sda, sda_oe, sda_o, standby, commit;
  logic [15:0] c_addr;
  logic [7:0]  c_data;
  int n_fail = 0;
  int checks = 0;
  int n_commit = 0;
  // Pulled-up wire: low when either side pulls
  assign sda = m_sda & !sda_oe;
  scc_master mst_u (.sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  scc_eeprom_ctrl #(.INIT_CYC(2000)) dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda), .dev_sel_i(SEL), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .standby_o(standby), .write_commit_o(commit),
    .commit_addr_o(c_addr), .commit_data_o(c_data));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = !core_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7 forever #80 link_clk_i = !link_clk_i;
  end
  always @(posedge core_clk_i) if (commit === 1'b1) n_commit++;
  task automatic chk_val(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, a, e);
    end
  endtask : chk_val
  task automatic tx(input logic [7:0] b, input logic e);
    logic k;
    mst_u.tx_byte(b, 1'b0, k);
    chk_val(k, e);
  endtask : tx
  // nd: data bits sent; 8 is byte plus ack, 9 adds one more bit
  task automatic cmd(input logic [15:0] a, input logic [7:0] d, input int nd, input logic g);
    logic r;
    int n0;
    n0 = n_commit;
    mst_u.start();
    tx(DEV, 1'b1);
    tx(a[15:8], 1'b1);
    tx(a[7:0], 1'b1);
    if (nd >= 8) begin
      mst_u.tx_byte(d, g, r);
      chk_val(r, 1'b1);
    end
    for (int i = 0; i < ((nd == 9) ? 1 : nd % 8); i++) mst_u.bit_io(d[7 - i], 1'b0, r);
    mst_u.stop();
    repeat (40) @(posedge core_clk_i);
    chk_val(n_commit, n0 + (nd == 8));
    if (nd == 8) chk_val({c_addr, c_data}, {a, d});
  endtask : cmd
  task automatic t_lock();
    logic k;
    chk_val(standby, 1'b0);
    mst_u.start();
    mst_u.tx_byte(DEV, 1'b0, k);
    chk_val(k, 1'b0);
    mst_u.stop();
    for (int i = 0; i < 3000 && standby !== 1'b1; i++) @(posedge core_clk_i);
    chk_val(standby, 1'b1);
    repeat (40) @(posedge core_clk_i);
  endtask : t_lock
  // Full address reload after the cancel
  task automatic t_cancel();
    logic r;
    mst_u.start();
    tx(DEV, 1'b1);
    for (int i = 0; i < 3; i++) mst_u.bit_io(1'b1, 1'b0, r);
    cmd(16'h0a5a, 8'h5c, 8, 1'b0);
  endtask : t_cancel
  task automatic t_resync();
    logic r;
    int n0;
    n0 = n_commit;
    mst_u.start();
    tx(DEV, 1'b1);
    tx(8'h01, 1'b1);
    for (int i = 0; i < 9; i++) mst_u.bit_io(1'b1, 1'b0, r);
    mst_u.start();
    mst_u.stop();
    repeat (40) @(posedge core_clk_i);
    chk_val(n_commit, n0);
    cmd(16'h7e81, 8'h96, 8, 1'b0);
  endtask : t_resync
  // Foreign address is ignored, a read is acked and then left alone
  task automatic t_foreign();
    int n0;
    n0 = n_commit;
    mst_u.start();
    tx({`SCC_DEV_PREFIX, SEL ^ 3'h1, 1'b0}, 1'b0);
    mst_u.stop();
    mst_u.start();
    tx(DEV | 8'h01, 1'b1);
    mst_u.stop();
    repeat (40) @(posedge core_clk_i);
    chk_val(n_commit, n0);
    chk_val(sda_o, 1'b0);
  endtask : t_foreign
  // Second power-on clear in mid-run
  task automatic t_reset();
    int n0;
    @(posedge core_clk_i);
    #1 rst_n_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    chk_val({c_addr, c_data}, 24'h00_0000);
    n0 = n_commit;
    t_lock();
    chk_val(n_commit, n0);
    cmd(16'h2468, 8'h3c, 8, 1'b0);
  endtask : t_reset
  task automatic stop_test();
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    rst_n_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    t_lock();
    cmd(16'h1234, 8'ha5, 8, 1'b0);
    cmd(16'h00ff, 8'hf0, 8, 1'b1);
    cmd(16'h0102, 8'h33, 0, 1'b0);
    cmd(16'h0102, 8'h33, 4, 1'b0);
    cmd(16'h0102, 8'h33, 9, 1'b0);
    t_cancel();
    t_resync();
    t_foreign();
    t_reset();
    stop_test();
  end
  initial begin
    #2_000_000 n_fail++;
    stop_test();
  end
endmodule : testbench
